//--- single_wire_program_port_defines.svh
// Constants of the single-wire programming port: timing, codes, field positions and reset values.
// Summary of operation
// - Right after the command byte exactly nine data bits move, written or read, least significant bit first.
// - Once the data bits are done, the port only accepts a new transaction after a fresh reset pulse.
// - Every falling edge of the data line restarts the port's slot delay timer.
// - In a write slot the port samples the line when the sample delay expires and takes that level as the bit.
// - In a read slot carrying 0 the port holds the line low until the hold delay expires.
// - In a read slot carrying 1 the port leaves the line alone.
// - Without the programming strap at power-up the part runs normally on its stored configuration.
// - An unprogrammed part holds an all-zero divider word, so the divider divides by two.
// - The default mode word has the prescaler bypass field set to 1.
// - The default mode word has the divide-by-one select field cleared to 0.
// - Each transaction opens with a master reset pulse that the port answers with a presence pulse.
// - After presence the master sends an eight-bit command, least significant bit first.
// - Command 01h writes the divider word and 02h writes the mode word with the following nine bits.
// - Command A1h reads the divider word and A2h reads the mode word in the following nine slots.
`ifndef SINGLE_WIRE_PROGRAM_PORT_DEFINES_SVH
`define SINGLE_WIRE_PROGRAM_PORT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS   4
`define RESET_MIN_NS    480000
`define PRES_WAIT_NS    30000
`define PRES_LEN_NS     120000
`define SAMPLE_NS       30000
`define HOLD_NS         45000

// ----------------------------------------------------------------------------
// Framing and commands
// ----------------------------------------------------------------------------
`define CMD_BITS        8
`define DATA_BITS       9
`define CMD_WR_DIVIDER  8'h01
`define CMD_WR_MODE     8'h02
`define CMD_RD_DIVIDER  8'hA1
`define CMD_RD_MODE     8'hA2

// ----------------------------------------------------------------------------
// Mode word fields and reset values
// ----------------------------------------------------------------------------
`define MODE_ONE_BIT    1
`define MODE_BYPASS_BIT 2
`define MODE_HALF_BIT   3
`define DIVIDER_RESET   9'h000
`define MODE_RESET      9'h034

`endif

//--- program_port_pkg.sv
// Types shared by the single-wire programming port.
`default_nettype none
package program_port_pkg;

	// Gray-coded along reset, presence, command, data, done.
	typedef enum logic [2:0] {
		ST_IDLE       = 3'b000,
		ST_RESET_LOW  = 3'b001,
		ST_PRES_WAIT  = 3'b011,
		ST_PRES_DRIVE = 3'b010,
		ST_COMMAND    = 3'b110,
		ST_DATA       = 3'b111,
		ST_DONE       = 3'b101,
		ST_NORMAL     = 3'b100
	} state_t;

	typedef enum logic {
		SEL_DIVIDER = 1'b0,
		SEL_MODE    = 1'b1
	} word_sel_t;

endpackage
`default_nettype wire

//--- slot_if.sv
// Carrier between the slot timer and the port controller.
`timescale 1ns/1ps
`default_nettype none
interface slot_if #(
	parameter int CNT_W = 18
);
	logic             fall;
	logic [CNT_W-1:0] since_fall;

	modport timer (output fall, output since_fall);
	modport user (input fall, input since_fall);
endinterface
`default_nettype wire

//--- slot_timer.sv
// Delay timer that restarts on each falling edge of the data line.
`timescale 1ns/1ps
`default_nettype none
module slot_timer #(
	parameter int CNT_W = 18
) (
	// Clock and reset
	input  wire logic  sys_clk,
	input  wire logic  rst_n,
	// Data line level
	input  wire logic  dq_in,
	// Timer view
	slot_if.timer      slot
);

	logic             dq_prev;
	logic             next_dq_prev;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;

	// ----------------------------------------------------------------------------
	// Edge and counter
	// ----------------------------------------------------------------------------
	// The counter saturates so a long low level is still measured once.
	always_comb begin
		next_dq_prev = dq_in;
		next_count   = count;
		if (dq_prev && !dq_in) begin
			next_count = '0;
		end else if (count != {CNT_W{1'b1}}) begin
			next_count = count + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dq_prev <= 1'b1;
			count   <= {CNT_W{1'b1}};
		end else begin
			dq_prev <= next_dq_prev;
			count   <= next_count;
		end
	end

	assign slot.fall       = dq_prev && !dq_in;
	assign slot.since_fall = count;

endmodule // slot_timer
`default_nettype wire

//--- single_wire_program_port.sv
// Device side of the single-wire programming port and its configuration words.
`timescale 1ns/1ps
`default_nettype none
`include "single_wire_program_port_defines.svh"
module single_wire_program_port #(
	parameter int CNT_W          = 18,
	parameter int RESET_MIN_CYC  = (`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter int PRES_WAIT_CYC  = (`PRES_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter int PRES_LEN_CYC   = (`PRES_LEN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter int SAMPLE_CYC     = `SAMPLE_NS / `CLK_PERIOD_NS,
	parameter int HOLD_CYC       = (`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Programming strap, level of the pin at power-up
	input  wire logic        program_strap,
	// Data pin, open drain
	input  wire logic        dq_in,
	output logic             dq_out,
	output logic             dq_oe_n,
	// Configuration words
	output logic [8:0]       divider_word,
	output logic [8:0]       mode_word,
	output logic             prescaler_bypass,
	output logic             divide_by_one_select,
	output logic             prescaler_by_two,
	// Status
	output logic             program_mode,
	output logic             nv_store,
	output logic             nv_store_mode,
	output logic             presence_sent,
	output logic             command_error
);

	// ----------------------------------------------------------------------------
	// State
	// ----------------------------------------------------------------------------
	program_port_pkg::state_t    state;
	program_port_pkg::state_t    next_state;
	program_port_pkg::word_sel_t sel;
	program_port_pkg::word_sel_t next_sel;
	logic [8:0]                  shift;
	logic [8:0]                  next_shift;
	logic [3:0]                  bit_cnt;
	logic [3:0]                  next_bit_cnt;
	logic                        reading;
	logic                        next_reading;
	logic                        slot_open;
	logic                        next_slot_open;
	logic                        drive;
	logic                        next_drive;
	logic [CNT_W-1:0]            pres_cnt;
	logic [CNT_W-1:0]            next_pres_cnt;
	logic [8:0]                  next_divider_word;
	logic [8:0]                  next_mode_word;
	logic                        next_program_mode;
	logic                        next_nv_store;
	logic                        next_nv_store_mode;
	logic                        next_presence_sent;
	logic                        next_command_error;
	logic                        reset_seen;
	logic                        tick;
	logic [8:0]                  shifted_in;

	slot_if #(.CNT_W(CNT_W)) slot ();

	slot_timer #(
		.CNT_W (CNT_W)
	) u_timer (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.dq_in   (dq_in),
		.slot    (slot.timer)
	);

	function automatic logic at(input logic [CNT_W-1:0] cnt, input int n);
		return cnt == n[CNT_W-1:0];
	endfunction

	// ----------------------------------------------------------------------------
	// Slot timing
	// ----------------------------------------------------------------------------
	// A reset pulse is recognised the moment the low level has lasted long enough, in program mode only and in any state but ST_IDLE.
	assign reset_seen = program_mode && !dq_in && at(slot.since_fall, RESET_MIN_CYC);
	// One tick per slot: at the sample point for writes, at the end of the hold for reads.
	assign tick       = slot_open && at(slot.since_fall,
		reading ? HOLD_CYC - 1 : SAMPLE_CYC - 1);
	assign shifted_in = {dq_in, shift[8:1]};

	// ----------------------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------------------
	always_comb begin
		next_state         = state;
		next_sel           = sel;
		next_shift         = shift;
		next_bit_cnt       = bit_cnt;
		next_reading       = reading;
		next_slot_open     = slot_open;
		next_drive         = drive;
		next_pres_cnt      = pres_cnt;
		next_divider_word  = divider_word;
		next_mode_word     = mode_word;
		next_program_mode  = program_mode;
		next_nv_store      = 1'b0;
		next_nv_store_mode = nv_store_mode;
		next_presence_sent = 1'b0;
		next_command_error = 1'b0;
		case (state)
			program_port_pkg::ST_IDLE: begin
				// The strap is taken on the first edge after reset release.
				next_program_mode = program_strap;
				next_state        = program_strap ? program_port_pkg::ST_DONE
					: program_port_pkg::ST_NORMAL;
			end
			program_port_pkg::ST_RESET_LOW: begin
				if (dq_in) begin
					next_pres_cnt = '0;
					next_state    = program_port_pkg::ST_PRES_WAIT;
				end
			end
			program_port_pkg::ST_PRES_WAIT: begin
				next_pres_cnt = pres_cnt + 1'b1;
				if (at(pres_cnt, PRES_WAIT_CYC - 1)) begin
					next_pres_cnt = '0;
					next_drive    = 1'b1;
					next_state    = program_port_pkg::ST_PRES_DRIVE;
				end
			end
			program_port_pkg::ST_PRES_DRIVE: begin
				next_pres_cnt = pres_cnt + 1'b1;
				if (at(pres_cnt, PRES_LEN_CYC - 1)) begin
					next_drive         = 1'b0;
					next_presence_sent = 1'b1;
					next_bit_cnt       = '0;
					next_slot_open     = 1'b0;
					next_reading       = 1'b0;
					next_state         = program_port_pkg::ST_COMMAND;
				end
			end
			program_port_pkg::ST_COMMAND: begin
				if (slot.fall) begin
					next_slot_open = 1'b1;
				end
				if (tick) begin
					next_slot_open = 1'b0;
					next_shift     = shifted_in;
					next_bit_cnt   = bit_cnt + 1'b1;
					if (bit_cnt == 4'(`CMD_BITS - 1)) begin
						next_bit_cnt = '0;
						next_state   = program_port_pkg::ST_DATA;
						if (shifted_in[8:1] == `CMD_WR_DIVIDER) begin
							next_sel = program_port_pkg::SEL_DIVIDER;
						end else if (shifted_in[8:1] == `CMD_WR_MODE) begin
							next_sel = program_port_pkg::SEL_MODE;
						end else if (shifted_in[8:1] == `CMD_RD_DIVIDER) begin
							next_sel     = program_port_pkg::SEL_DIVIDER;
							next_reading = 1'b1;
							next_shift   = divider_word;
						end else if (shifted_in[8:1] == `CMD_RD_MODE) begin
							next_sel     = program_port_pkg::SEL_MODE;
							next_reading = 1'b1;
							next_shift   = mode_word;
						end else begin
							// Unknown command: stay silent until the next reset pulse.
							next_command_error = 1'b1;
							next_state         = program_port_pkg::ST_DONE;
						end
					end
				end
			end
			program_port_pkg::ST_DATA: begin
				if (slot.fall) begin
					next_slot_open = 1'b1;
					// Only a 0 bit pulls the line; a 1 leaves the slot as the master made it.
					next_drive     = reading && !shift[0];
				end
				if (tick) begin
					next_slot_open = 1'b0;
					next_drive     = 1'b0;
					next_bit_cnt   = bit_cnt + 1'b1;
					next_shift     = reading ? {1'b0, shift[8:1]} : shifted_in;
					if (bit_cnt == 4'(`DATA_BITS - 1)) begin
						next_state = program_port_pkg::ST_DONE;
						if (!reading) begin
							next_nv_store      = 1'b1;
							next_nv_store_mode = (sel == program_port_pkg::SEL_MODE);
							if (sel == program_port_pkg::SEL_MODE) begin
								next_mode_word = shifted_in;
							end else begin
								next_divider_word = shifted_in;
							end
						end
					end
				end
			end
			program_port_pkg::ST_DONE: begin
				next_slot_open = 1'b0;
				next_drive     = 1'b0;
			end
			default: begin
				// Normal operation: the pin belongs to the oscillator, the port never drives it.
				next_drive = 1'b0;
			end
		endcase
		// A reset pulse aborts whatever transfer was under way.
		if (reset_seen && state != program_port_pkg::ST_IDLE) begin
			next_state     = program_port_pkg::ST_RESET_LOW;
			next_drive     = 1'b0;
			next_slot_open = 1'b0;
		end
	end

	// ----------------------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------------------
	// The words come back to their shipped values on reset; a nonvolatile store
	// outside this block is told of each write through nv_store.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state         <= program_port_pkg::ST_IDLE;
			sel           <= program_port_pkg::SEL_DIVIDER;
			shift         <= 9'h000;
			bit_cnt       <= 4'h0;
			reading       <= 1'b0;
			slot_open     <= 1'b0;
			drive         <= 1'b0;
			pres_cnt      <= '0;
			divider_word  <= `DIVIDER_RESET;
			mode_word     <= `MODE_RESET;
			program_mode  <= 1'b0;
			nv_store      <= 1'b0;
			nv_store_mode <= 1'b0;
			presence_sent <= 1'b0;
			command_error <= 1'b0;
		end else begin
			state         <= next_state;
			sel           <= next_sel;
			shift         <= next_shift;
			bit_cnt       <= next_bit_cnt;
			reading       <= next_reading;
			slot_open     <= next_slot_open;
			drive         <= next_drive;
			pres_cnt      <= next_pres_cnt;
			divider_word  <= next_divider_word;
			mode_word     <= next_mode_word;
			program_mode  <= next_program_mode;
			nv_store      <= next_nv_store;
			nv_store_mode <= next_nv_store_mode;
			presence_sent <= next_presence_sent;
			command_error <= next_command_error;
		end
	end

	// ----------------------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------------------
	// Open drain: the pin is only ever pulled low.
	assign dq_out               = 1'b0;
	assign dq_oe_n              = !drive;
	assign prescaler_bypass     = mode_word[`MODE_BYPASS_BIT];
	assign divide_by_one_select = mode_word[`MODE_ONE_BIT];
	assign prescaler_by_two     = mode_word[`MODE_HALF_BIT];

endmodule // single_wire_program_port
`default_nettype wire

//--- program_port_props.sv
// Assertion checker for the single-wire programming port, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module program_port_props #(
	parameter int PRES_WAIT_CYC = 5,
	parameter int PRES_LEN_CYC  = 10,
	parameter int HOLD_CYC      = 12
) (
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       rst_n,
	// Data pin
	input wire logic       dq_in,
	input wire logic       dq_out,
	input wire logic       dq_oe_n,
	// Words and status
	input wire logic [8:0] divider_word,
	input wire logic [8:0] mode_word,
	input wire logic       prescaler_bypass,
	input wire logic       divide_by_one_select,
	input wire logic       program_mode,
	input wire logic       nv_store,
	input wire logic       nv_store_mode,
	input wire logic       presence_sent
);
	logic [17:0] low_cnt;

	// Length of the current low drive, so both drive lengths can be checked exactly.
	always_ff @(posedge sys_clk) begin
		if (!rst_n || dq_oe_n)
			low_cnt <= 18'h0_0000;
		else
			low_cnt <= low_cnt + 18'h0_0001;
	end

	a_pin_low_only: assert property (@(posedge sys_clk) dq_out == 1'b0)
		else $error("data pin driven high");
	a_reset_defaults: assert property (@(posedge sys_clk) !rst_n |=>
		divider_word == 9'h000 && mode_word == 9'h034 && dq_oe_n) else $error("reset values wrong");
	a_bypass_field: assert property (@(posedge sys_clk) disable iff (!rst_n)
		prescaler_bypass == mode_word[2]) else $error("bypass field mismatch");
	a_one_select_field: assert property (@(posedge sys_clk) disable iff (!rst_n)
		divide_by_one_select == mode_word[1]) else $error("divide by one field mismatch");
	a_normal_silent: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!program_mode |-> dq_oe_n) else $error("pin driven in normal operation");
	a_divider_commit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$changed(divider_word) |-> nv_store && !nv_store_mode) else $error("divider changed without store");
	a_mode_commit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$changed(mode_word) |-> nv_store && nv_store_mode) else $error("mode changed without store");
	a_store_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
		nv_store |=> !nv_store) else $error("store pulse too long");
	a_presence_length: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(dq_oe_n) && presence_sent |-> low_cnt == PRES_LEN_CYC) else $error("presence length wrong");
	a_read_zero_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(dq_oe_n) && !presence_sent |-> low_cnt == HOLD_CYC) else $error("read hold length wrong");
	a_presence_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(dq_oe_n) && $past(dq_in) |-> $past(dq_in, PRES_WAIT_CYC)) else $error("presence too early");
endmodule // program_port_props

bind single_wire_program_port program_port_props #(.PRES_WAIT_CYC(PRES_WAIT_CYC), .PRES_LEN_CYC(PRES_LEN_CYC),
	.HOLD_CYC(HOLD_CYC)) props_inst (.sys_clk(sys_clk), .rst_n(rst_n), .dq_in(dq_in), .dq_out(dq_out),
	.dq_oe_n(dq_oe_n), .divider_word(divider_word), .mode_word(mode_word), .prescaler_bypass(prescaler_bypass),
	.divide_by_one_select(divide_by_one_select), .program_mode(program_mode), .nv_store(nv_store),
	.nv_store_mode(nv_store_mode), .presence_sent(presence_sent));
`default_nettype wire

//--- line_master.sv
// Behavioural bus master that opens every slot on the shared data line.
`timescale 1ns/1ps
`default_nettype none
module line_master #(
	parameter int RESET_CYC = 48,
	parameter int SLOT_CYC  = 18
) (
	// Clock
	input  wire logic sys_clk,
	// Device drive
	input  wire logic dq_out,
	input  wire logic dq_oe_n,
	// Resolved line
	output logic      line
);
	logic pull_low = 1'b0;

	// The pullup wins unless one of the parties pulls low.
	assign line = !pull_low && (dq_oe_n || dq_out);

	task automatic reset_pulse(output logic seen);
		seen = 1'b0;
		pull_low <= 1'b1;
		repeat (RESET_CYC) @(posedge sys_clk);
		pull_low <= 1'b0;
		repeat (60) begin
			@(posedge sys_clk);
			if (dq_oe_n === 1'b0)
				seen = 1'b1;
		end
	endtask

	// A zero is held well past the sample point; the next fall comes after the hold tick.
	task automatic slot(input logic wr_bit, input logic is_read, output logic rd_bit);
		pull_low <= 1'b1;
		repeat (2) @(posedge sys_clk);
		if (is_read || wr_bit)
			pull_low <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rd_bit = line;
		repeat (6) @(posedge sys_clk);
		pull_low <= 1'b0;
		repeat (SLOT_CYC - 12) @(posedge sys_clk);
	endtask
endmodule // line_master
`default_nettype wire

//--- tb_single_wire_program_port.sv
// Self-checking testbench for the single-wire programming port.
`timescale 1ns/1ps
`default_nettype none
module tb_single_wire_program_port;
	typedef struct packed {
		logic [7:0] cmd;
		logic [8:0] wdata;
		logic       rd;
		logic [8:0] exp_div;
		logic [8:0] exp_mode;
	} row_t;

	logic       sys_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       program_strap = 1'b1;
	logic       dq_in;
	logic       dq_out;
	logic       dq_oe_n;
	logic       bypass;
	logic       one_sel;
	logic       command_error;
	logic       half;
	logic       program_mode;
	logic       nv_store;
	logic       nv_store_mode;
	logic       presence_sent;
	logic       err_seen = 1'b0;
	logic [8:0] div_stores = 9'h000;
	logic [8:0] mode_stores = 9'h000;
	logic [8:0] presences = 9'h000;
	logic       b;
	logic [8:0] divider_word;
	logic [8:0] mode_word;
	logic [8:0] rdata;
	int         n_errors = 0;
	int         checks_done = 0;
	row_t       rows [8];

	always #2 sys_clk = ~sys_clk;

	always @(posedge sys_clk)
		if (command_error === 1'b1)
			err_seen <= 1'b1;

	// Pulses are counted so that each store and each presence can be checked against the scenario.
	always @(posedge sys_clk) begin
		if (nv_store === 1'b1 && nv_store_mode === 1'b1)
			mode_stores <= mode_stores + 9'h001;
		if (nv_store === 1'b1 && nv_store_mode === 1'b0)
			div_stores <= div_stores + 9'h001;
		if (presence_sent === 1'b1)
			presences <= presences + 9'h001;
	end

	single_wire_program_port #(.RESET_MIN_CYC(40), .PRES_WAIT_CYC(5), .PRES_LEN_CYC(10), .SAMPLE_CYC(8),
		.HOLD_CYC(12)) single_wire_program_port_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.program_strap(program_strap), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
		.divider_word(divider_word), .mode_word(mode_word), .prescaler_bypass(bypass),
		.divide_by_one_select(one_sel), .prescaler_by_two(half), .program_mode(program_mode),
		.nv_store(nv_store), .nv_store_mode(nv_store_mode), .presence_sent(presence_sent),
		.command_error(command_error));

	line_master line_master_inst (.sys_clk(sys_clk), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .line(dq_in));

	task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic summarize();
		$display("checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic do_reset(input logic strap);
		rst_n <= 1'b0;
		program_strap <= strap;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
	endtask

	task automatic txn(input logic [7:0] cmd, input logic [8:0] wdata, input logic rd, input int nbits,
		input logic pres);
		logic seen;
		line_master_inst.reset_pulse(seen);
		check("presence", {8'h00, pres}, {8'h00, seen});
		for (int i = 0; i < 8; i++)
			line_master_inst.slot(cmd[i], 1'b0, b);
		for (int i = 0; i < nbits; i++) begin
			line_master_inst.slot(wdata[i], rd, b);
			rdata[i] = b;
		end
	endtask

	initial begin
		do_reset(1'b1);
		rows[0] = '{8'hA1, 9'h000, 1'b1, 9'h000, 9'h034};
		rows[1] = '{8'hA2, 9'h000, 1'b1, 9'h000, 9'h034};
		rows[2] = '{8'h01, 9'h1A5, 1'b0, 9'h1A5, 9'h034};
		rows[3] = '{8'hA1, 9'h000, 1'b1, 9'h1A5, 9'h034};
		rows[4] = '{8'h02, 9'h03A, 1'b0, 9'h1A5, 9'h03A};
		rows[5] = '{8'hA2, 9'h000, 1'b1, 9'h1A5, 9'h03A};
		rows[6] = '{8'h01, 9'h1FF, 1'b0, 9'h1FF, 9'h03A};
		rows[7] = '{8'hA1, 9'h000, 1'b1, 9'h1FF, 9'h03A};
		foreach (rows[k]) begin
			txn(rows[k].cmd, rows[k].wdata, rows[k].rd, 9, 1'b1);
			if (rows[k].rd)
				check("read word", rows[k].cmd[1] ? rows[k].exp_mode : rows[k].exp_div, rdata);
			check("divider word", rows[k].exp_div, divider_word);
			check("mode word", rows[k].exp_mode, mode_word);
			check("bypass", {8'h00, rows[k].exp_mode[2]}, {8'h00, bypass});
			check("one select", {8'h00, rows[k].exp_mode[1]}, {8'h00, one_sel});
			check("prescaler by two", {8'h00, rows[k].exp_mode[3]}, {8'h00, half});
		end
		check("divider stores", 9'h002, div_stores);
		check("mode stores", 9'h001, mode_stores);
		check("presence pulses", 9'h008, presences);
		// A write command and zero data without a fresh reset pulse must be ignored.
		for (int i = 0; i < 17; i++)
			line_master_inst.slot(i == 0, 1'b0, b);
		check("divider after extra slots", 9'h1FF, divider_word);
		txn(8'h01, 9'h000, 1'b0, 4, 1'b1);
		txn(8'hA1, 9'h000, 1'b1, 9, 1'b1);
		check("read after abort", 9'h1FF, rdata);
		txn(8'h55, 9'h000, 1'b0, 9, 1'b1);
		check("command error", 9'h001, {8'h00, err_seen});
		check("divider after bad command", 9'h1FF, divider_word);
		do_reset(1'b1);
		check("program mode", 9'h001, {8'h00, program_mode});
		check("default divider", 9'h000, divider_word);
		check("default mode", 9'h034, mode_word);
		check("default bypass", 9'h001, {8'h00, bypass});
		check("default one select", 9'h000, {8'h00, one_sel});
		do_reset(1'b0);
		check("normal mode", 9'h000, {8'h00, program_mode});
		txn(8'hA1, 9'h000, 1'b1, 9, 1'b0);
		check("line in normal mode", 9'h1FF, rdata);
		summarize();
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		$display("unexpected run length: expected end, seen watchdog");
		summarize();
	end
endmodule // tb_single_wire_program_port
`default_nettype wire
